// ### cdf_chan_filter.sv
/*
 * One channel's diagnosis delay filter.
 * Assumes raw condition is already synchronised to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
module cdf_chan_filter
    import cdf_pkg::*;
#(
    parameter bit EXTENDED = 1'b0
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] raw_code,
    input  wire logic [1:0] blind_sel,
    output logic            commit,
    output logic [1:0]      commit_code
);
    logic [CDF_CNT_W-1:0] cnt_q;
    logic [CDF_CNT_W-1:0] limit;
    logic [1:0]           prev_q;
    logic                 run_q;
    logic                 swap;
    logic                 change;

    always_comb begin
        limit = CDF_CNT_W'(CDF_TD_STD_CYC);
        if (EXTENDED && blind_sel[0]) begin // R06 R07
            limit = blind_sel[1] ? CDF_CNT_W'(CDF_TD_LONG_CYC)
                                 : CDF_CNT_W'(CDF_TD_MID_CYC);
        end
    end

    // Swap between open load and short keeps the timer running
    assign swap = (prev_q == CDF_OPEN_LOAD && raw_code == CDF_SHORT_TO_GROUND)
               || (prev_q == CDF_SHORT_TO_GROUND && raw_code == CDF_OPEN_LOAD); // R05
    assign change = (raw_code != prev_q) && !(swap && run_q); // R18

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q  <= '0;
            prev_q <= CDF_NO_FAULT;
            run_q  <= 1'b0;
        end else begin
            prev_q <= raw_code;
            if (change) begin // R18
                cnt_q <= '0;
                run_q <= 1'b1;
            end else if (run_q && cnt_q >= limit - 1'b1) begin // R04
                run_q <= 1'b0;
            end else if (run_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign commit      = run_q && !change && (cnt_q >= limit - 1'b1);
    assign commit_code = raw_code; // R05
endmodule
`default_nettype wire

// ### cdf_device.sv
/*
 * Device end: per-channel diagnosis filter, diagnosis register, overload
 * latch and output control for ten low-side channels.
 * Assumes the raw fault flags arrive from analog comparators asynchronously.
 */
`timescale 1ns/10ps
`default_nettype none
// Function
// [R01] Two-bit code per channel diagnosis
// [R02] Overload switches channel off, stores code 10
// [R03] Newest diagnosis overwrites stored code
// [R04] Store only after filter delay elapsed
// [R05] Open-short swap keeps filter timer running
// [R06] Blind-time selects set channel 7-10 delay
// [R07] Extended delays kept within their limits
// [R08] Host keeps channels off beyond filter delay; its off wait passes the standard delay, not channel 7-10 blind-time delays
// [R09] Host pairs channels 7-8 and 9-10; the host sequencer switches one channel at a time, unpaired
// [R10] Host confirms open load after off time
// [R11] Host disables, clears, forces overloaded channel on
// [R12] Host rereads overload, then re-enables diagnosis
// [R13] Clear command restores no-fault entries
// [R14] Ten parallel inputs, one per channel
// [R15] Low parallel input switches channel off
// [R16] Overload latch holds until clear or overwrite
// [R17] Overload during write is stored afterwards
// [R18] Per-channel counter reloads on class change
// [R19] On request combines inputs, forced off latched
module cdf_device
    import cdf_pkg::*;
#(
    parameter int NCH = CDF_NCH
) (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    cdf_if.device               link,
    input  wire logic [NCH-1:0] scg_raw,
    input  wire logic [NCH-1:0] ol_raw,
    input  wire logic [NCH-1:0] oct_raw,
    output logic [NCH-1:0]      power_stage_n
);
    // The diagnosis word is laid out for ten channels
    if (NCH != CDF_NCH) begin : g_bad_nch
        $error("cdf_device serves ten channels only");
    end

    logic [NCH-1:0] s1_q;
    logic [NCH-1:0] s2_q;
    logic [NCH-1:0] s3_q;
    logic [NCH-1:0] o1_q;
    logic [NCH-1:0] o2_q;
    logic [NCH-1:0] o3_q;
    logic [NCH-1:0] t1_q;
    logic [NCH-1:0] t2_q;
    logic [NCH-1:0] t3_q;
    logic [NCH-1:0] scg_q;
    logic [NCH-1:0] ol_q;
    logic [NCH-1:0] oct_q;
    logic [NCH-1:0] oct_new;
    logic [NCH-1:0] hold_off;
    logic [NCH-1:0] latch_q;
    logic [NCH-1:0] pend_q;
    logic [NCH-1:0] commit;
    logic [2*NCH-1:0] ccode;
    logic [2*NCH-1:0] diag_q;
    logic [NCH-1:0] on_req;
    logic           wr_q;

    function automatic logic [1:0] classify(input logic s, input logic o,
                                           input logic t);
        if (t)      classify = CDF_OVERCURRENT_OVERTEMP;
        else if (s) classify = CDF_SHORT_TO_GROUND;
        else if (o) classify = CDF_OPEN_LOAD;
        else        classify = CDF_NO_FAULT; // R01
    endfunction

    // Take a new level only once the second and third stages agree
    function automatic logic [NCH-1:0] settle(input logic [NCH-1:0] st2,
                                              input logic [NCH-1:0] st3,
                                              input logic [NCH-1:0] held);
        settle = (st2 & ~(st2 ^ st3)) | (held & (st2 ^ st3));
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Three-stage input capture, change taken when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {s1_q, s2_q, s3_q} <= '0;
            {o1_q, o2_q, o3_q} <= '0;
            {t1_q, t2_q, t3_q} <= '0;
        end else begin
            {s3_q, s2_q, s1_q} <= {s2_q, s1_q, scg_raw};
            {o3_q, o2_q, o1_q} <= {o2_q, o1_q, ol_raw};
            {t3_q, t2_q, t1_q} <= {t2_q, t1_q, oct_raw};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scg_q <= '0;
            ol_q  <= '0;
            oct_q <= '0;
        end else begin
            scg_q <= settle(s2_q, s3_q, scg_q);
            ol_q  <= settle(o2_q, o3_q, ol_q);
            oct_q <= settle(t2_q, t3_q, oct_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-channel filters; channels 7 to 10 honour blind time
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic       off_diag;
            logic [1:0] raw;
            assign off_diag = link.off_diag_enable[g] || !oct_q[g];
            assign raw = off_diag ? classify(scg_q[g], ol_q[g], oct_q[g])
                                  : CDF_NO_FAULT;
            cdf_chan_filter #(
                .EXTENDED (g >= CDF_EXT_FIRST)
            ) u_filt (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .raw_code    (raw),
                .blind_sel   ({link.blind_time_sel_b, link.blind_time_sel_a}),
                .commit      (commit[g]),
                .commit_code (ccode[2*g+1:2*g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Diagnosis register: last result wins, clear restores no fault
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= |commit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            diag_q <= CDF_DIAG_RST;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (link.diag_clear_cmd) begin
                    diag_q[2*i +: 2] <= CDF_NO_FAULT; // R13
                end
                if (commit[i]) begin
                    diag_q[2*i +: 2] <= ccode[2*i +: 2]; // R03
                end
                if (pend_q[i] || (oct_new[i] && !wr_q)) begin
                    diag_q[2*i +: 2] <= CDF_OVERCURRENT_OVERTEMP; // R02
                end
            end
        end
    end

    // Overload arriving during a write cycle is held, stored after it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= oct_new & {NCH{wr_q}}; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Overload latch, released by clear or by a different new diagnosis
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_q <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (oct_q[i]) begin
                    latch_q[i] <= 1'b1; // R02
                end else if (link.diag_clear_cmd
                          || (commit[i]
                              && ccode[2*i +: 2] != CDF_OVERCURRENT_OVERTEMP)) begin
                    latch_q[i] <= 1'b0; // R16
                end
            end
        end
    end

    // A fresh overload is one not yet latched
    assign oct_new  = oct_q & ~latch_q;

    // Latched or present overload keeps the stage off
    assign hold_off = latch_q | oct_q; // R02 R16

    // Input n drives channel n only; low input forces off
    assign on_req = link.parallel_gate_sig & link.serial_on; // R14 R15 R19

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_stage_n <= '0;
        end else begin
            power_stage_n <= on_req & ~hold_off; // R02 R16 R19
        end
    end

    assign link.diag_result_field = diag_q; // R01
    assign link.diag_busy         = wr_q;
endmodule
`default_nettype wire

// ### cdf_host.sv
/*
 * Controller end: AHB-Lite slave registers that drive the channel
 * controls and run the open-load and overload confirmation sequences.
 * Assumes one AHB-Lite master on hclk.
 */
`timescale 1ns/10ps
`default_nettype none
module cdf_host
    import cdf_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    cdf_if.host              link
);
    typedef enum {S_IDLE, S_OFF, S_OL_CHK, S_DIS, S_CLR, S_ON, S_OCT_CHK}
        cdf_state_t;
    cdf_state_t st_q;

    logic [31:0] ctrl_q;
    logic [9:0]  gate_q;
    logic [9:0]  chk_q;
    logic [9:0]  confirmed_q;
    logic [3:0]  ch_q;
    logic [15:0] wait_q;
    logic        wr_q;
    logic [7:0]  wa_q;
    logic        clr_q;
    logic [1:0]  code_now;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign code_now  = link.diag_result_field[2*ch_q +: 2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= '0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CDF_CTRL_RST;
            gate_q <= CDF_GATE_RST;
        end else if (wr_q) begin
            if (wa_q == CDF_REG_CTRL) ctrl_q <= hwdata;
            if (wa_q == CDF_REG_GATE) gate_q <= hwdata[9:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
                CDF_REG_CTRL:   hrdata <= ctrl_q;
                CDF_REG_GATE:   hrdata <= {22'h0, gate_q};
                CDF_REG_DIAG:   hrdata <= {12'h0, link.diag_result_field};
                CDF_REG_STATUS: hrdata <= {21'h0, st_q != S_IDLE,
                                           ch_q, 6'h0};
                CDF_REG_CHK:    hrdata <= {22'h0, confirmed_q};
                default:        hrdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Confirmation sequencer, one channel at a time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q        <= S_IDLE;
            chk_q       <= '0;
            confirmed_q <= '0;
            ch_q        <= '0;
            wait_q      <= '0;
            clr_q       <= 1'b0;
        end else begin
            clr_q <= 1'b0;
            if (wait_q != 0) wait_q <= wait_q - 1'b1;
            case (st_q)
                S_IDLE: begin
                    ch_q <= (ch_q == 4'h9) ? 4'h0 : ch_q + 1'b1;
                    if (code_now == CDF_OPEN_LOAD) begin
                        chk_q[ch_q] <= 1'b1;
                        wait_q <= 16'(CDF_OFF_WAIT_CYC); // R08 R10
                        st_q   <= S_OFF;
                        ch_q   <= ch_q;
                    end else if (code_now == CDF_OVERCURRENT_OVERTEMP) begin
                        st_q <= S_DIS;
                        ch_q <= ch_q;
                    end
                end
                S_OFF: if (wait_q == 0) st_q <= S_OL_CHK;
                S_OL_CHK: begin
                    confirmed_q[ch_q] <= code_now == CDF_OPEN_LOAD; // R10
                    chk_q[ch_q] <= 1'b0;
                    st_q <= S_IDLE;
                end
                S_DIS: begin
                    chk_q[ch_q] <= 1'b1; // R11
                    st_q <= S_CLR;
                end
                S_CLR: begin
                    clr_q  <= 1'b1; // R11
                    wait_q <= 16'(CDF_ON_WAIT_CYC);
                    st_q   <= S_ON;
                end
                S_ON: if (wait_q == 0) st_q <= S_OCT_CHK;
                S_OCT_CHK: begin
                    confirmed_q[ch_q] <= code_now == CDF_OVERCURRENT_OVERTEMP;
                    chk_q[ch_q] <= 1'b0; // R12
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // OL check holds channel off; overload check forces it on
    assign link.parallel_gate_sig = (st_q == S_OFF) || (st_q == S_OL_CHK)
        ? gate_q & ~(10'h001 << ch_q)
        : (st_q == S_ON ? gate_q | (10'h001 << ch_q) : gate_q); // R09
    assign link.serial_on = (st_q == S_ON) ? ctrl_q[9:0] | (10'h001 << ch_q)
                                           : ctrl_q[9:0]; // R11 R14
    assign link.off_diag_enable = ~chk_q | {10{st_q == S_OFF}};
    assign link.blind_time_sel_a = ctrl_q[CDF_CTRL_BTA];
    assign link.blind_time_sel_b = ctrl_q[CDF_CTRL_BTB];
    assign link.diag_clear_cmd = clr_q
        || (wr_q && wa_q == CDF_REG_CTRL && hwdata[CDF_CTRL_CLR]);
endmodule
`default_nettype wire

// ### cdf_if.sv
/*
 * Link between the diagnosis device end and the controller end.
 * Assumes both ends run on the same hclk.
 */
`timescale 1ns/10ps
`default_nettype none
interface cdf_if;
    logic [9:0]  parallel_gate_sig;
    logic [9:0]  serial_on;
    logic [9:0]  off_diag_enable;
    logic        blind_time_sel_a;
    logic        blind_time_sel_b;
    logic        diag_clear_cmd;
    logic [19:0] diag_result_field;
    logic        diag_busy;

    modport device (
        input  parallel_gate_sig, serial_on, off_diag_enable,
               blind_time_sel_a, blind_time_sel_b, diag_clear_cmd,
        output diag_result_field, diag_busy
    );
    modport host (
        output parallel_gate_sig, serial_on, off_diag_enable,
               blind_time_sel_a, blind_time_sel_b, diag_clear_cmd,
        input  diag_result_field, diag_busy
    );
endinterface
`default_nettype wire

// ### cdf_pkg.sv
/*
 * Package for the channel diagnosis filter: diagnosis codes, filter
 * delays and sizes shared by the device end and the controller end.
 * Assumes a 20 MHz clock on hclk.
 */
package cdf_pkg;
    localparam int unsigned CDF_NCH        = 10;
    localparam int unsigned CDF_CLK_HZ     = 20_000_000;
    // Filter delays in microseconds, typical figures inside the limits
    localparam int unsigned CDF_TD_STD_US  = 200;
    localparam int unsigned CDF_TD_MID_US  = 2500;
    localparam int unsigned CDF_TD_LONG_US = 5000;
    localparam int unsigned CDF_TD_MAX_US  = 220;
    localparam int unsigned CDF_LOD_MAX_US = 70;
    localparam int unsigned CDF_TD_STD_CYC  = CDF_TD_STD_US * (CDF_CLK_HZ / 1_000_000);
    localparam int unsigned CDF_TD_MID_CYC  = CDF_TD_MID_US * (CDF_CLK_HZ / 1_000_000);
    localparam int unsigned CDF_TD_LONG_CYC = CDF_TD_LONG_US * (CDF_CLK_HZ / 1_000_000);
    // Least waits of the controller, rounded up
    localparam int unsigned CDF_OFF_WAIT_CYC = CDF_TD_MAX_US * (CDF_CLK_HZ / 1_000_000) + 1;
    localparam int unsigned CDF_ON_WAIT_CYC  = CDF_LOD_MAX_US * (CDF_CLK_HZ / 1_000_000) + 1;
    localparam int unsigned CDF_CNT_W      = 17;
    localparam int unsigned CDF_EXT_FIRST  = 6;
    // Diagnosis codes
    localparam logic [1:0] CDF_SHORT_TO_GROUND      = 2'h0;
    localparam logic [1:0] CDF_OPEN_LOAD            = 2'h1;
    localparam logic [1:0] CDF_OVERCURRENT_OVERTEMP = 2'h2;
    localparam logic [1:0] CDF_NO_FAULT             = 2'h3;
    localparam logic [19:0] CDF_DIAG_RST = 20'hF_FFFF;
    // Controller register offsets and reset values
    localparam logic [7:0] CDF_REG_CTRL   = 8'h00;
    localparam logic [7:0] CDF_REG_GATE   = 8'h04;
    localparam logic [7:0] CDF_REG_DIAG   = 8'h08;
    localparam logic [7:0] CDF_REG_STATUS = 8'h0C;
    localparam logic [7:0] CDF_REG_CHK    = 8'h10;
    localparam logic [31:0] CDF_CTRL_RST  = 32'h0000_03FF;
    localparam logic [9:0]  CDF_GATE_RST  = 10'h000;
    localparam int unsigned CDF_CTRL_BTA  = 10;
    localparam int unsigned CDF_CTRL_BTB  = 11;
    localparam int unsigned CDF_CTRL_CLR  = 12;
endpackage

// ### cdf_props.sv
/*
 * Checker for the diagnosis link between the device and controller ends.
 * Assumes one hclk domain and the active-low asynchronous hresetn.
 */
`timescale 1ns/10ps
`default_nettype none
module cdf_props
    import cdf_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [9:0]  parallel_gate_sig,
    input wire logic [9:0]  serial_on,
    input wire logic        diag_clear_cmd,
    input wire logic [19:0] diag_result_field,
    input wire logic        diag_busy,
    input wire logic [9:0]  power_stage_n
);
    logic fresh_q;

    function automatic logic [9:0] oct_mask(input logic [19:0] f);
        for (int k = 0; k < 10; k++) begin
            oct_mask[k] = (f[2*k+:2] == CDF_OVERCURRENT_OVERTEMP);
        end
    endfunction

    // High in the first cycle after each reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    AST_RST_DIAG: assert property (fresh_q |-> diag_result_field == CDF_DIAG_RST)
        else $error("diagnosis not all no-fault after reset");
    AST_RST_OFF: assert property (fresh_q |-> power_stage_n == 10'h000)
        else $error("channel on right after reset");
    AST_GATE_OFF: assert property ((power_stage_n & ~$past(parallel_gate_sig)) == 10'h000)
        else $error("channel on with its parallel input low");
    AST_REQ_SRC: assert property ((power_stage_n & ~($past(parallel_gate_sig) & $past(serial_on))) == 10'h000)
        else $error("channel on without any on request");
    AST_OCT_OFF: assert property ((power_stage_n & oct_mask(diag_result_field) & oct_mask($past(diag_result_field))) == 10'h000)
        else $error("overloaded channel still on");
    AST_OCT_HOLD: assert property ((oct_mask(diag_result_field) != 10'h000) [*3] |-> (power_stage_n & oct_mask(diag_result_field)) == 10'h000)
        else $error("overload latch released while entry stands");
    AST_CLR: assert property (diag_clear_cmd |=> diag_busy || diag_result_field == CDF_DIAG_RST || oct_mask(diag_result_field) != 10'h000)
        else $error("diagnosis not cleared after clear command");
    AST_CAUSE: assert property (!$stable(diag_result_field) |-> diag_busy || $past(diag_clear_cmd) || (oct_mask(diag_result_field) & ~oct_mask($past(diag_result_field))) != 10'h000)
        else $error("diagnosis changed without a cause");
endmodule
`default_nettype wire

// ### channel_diagnosis_filter_tb.sv
/*
 * Self-checking bench: device and controller ends joined by the link,
 * driven over AHB-Lite and through the raw fault levels.
 * Assumes a 20 MHz hclk and the typical filter delays of the package.
 */
`timescale 1ns/10ps
`default_nettype none
module channel_diagnosis_filter_tb
    import cdf_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [9:0]  scg_raw;
    logic [9:0]  ol_raw;
    logic [9:0]  oct_raw;
    logic [9:0]  power_stage_n;
    logic [31:0] rd;
    int          num_errors;
    int          checks;

    cdf_if lnk ();

    cdf_device u_cdf_device (.hclk(hclk), .hresetn(hresetn), .link(lnk),
        .scg_raw(scg_raw), .ol_raw(ol_raw), .oct_raw(oct_raw),
        .power_stage_n(power_stage_n));
    cdf_host u_cdf_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(lnk));
    cdf_props u_cdf_props (.hclk(hclk), .hresetn(hresetn),
        .parallel_gate_sig(lnk.parallel_gate_sig),
        .serial_on(lnk.serial_on), .diag_clear_cmd(lnk.diag_clear_cmd),
        .diag_result_field(lnk.diag_result_field),
        .diag_busy(lnk.diag_busy), .power_stage_n(power_stage_n));

    initial hclk = 1'b0;
    always #25 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Address phase, then data phase; each held until hready is seen
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hreadyout !== 1'b1 && n < 64);
            if (hreadyout !== 1'b1) begin
                num_errors++;
                give_verdict();
            end
            if (p == 0) begin
                hsel <= 1'b0;
                htrans <= 2'b00;
                hwdata <= wd;
            end
        end
        rd = hrdata;
    endtask

    function automatic logic [1:0] code(input int ch);
        return lnk.diag_result_field[2*ch+:2];
    endfunction

    task automatic poll(input int ch, input logic [1:0] c, input int lim);
        int n;
        n = 0;
        while (code(ch) !== c && n < lim) begin
            @(posedge hclk);
            n++;
        end
        check(32'(code(ch)), 32'(c));
        if (code(ch) !== c) give_verdict();
    endtask

    // Read the status word until the confirmation sequencer is idle
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            ahb(1'b0, CDF_REG_STATUS, 32'h0);
            n++;
        end while (rd[10] !== 1'b0 && n < 3000);
        check(32'(rd[10]), 32'h0000_0000);
        if (rd[10] !== 1'b0) give_verdict();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        ahb(1'b0, CDF_REG_CTRL, 32'h0);
        check(rd, CDF_CTRL_RST);
        ahb(1'b0, CDF_REG_GATE, 32'h0);
        check(rd, 32'(CDF_GATE_RST));
        ahb(1'b0, CDF_REG_DIAG, 32'h0);
        check(rd, 32'(CDF_DIAG_RST));
        ahb(1'b1, 8'h14, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0000_0000);
        $display("done regs");
    endtask

    // Short then open load on channel 2; the swap must not restart timing
    task automatic t_filter();
        scg_raw[2] <= 1'b1;
        cyc(1000);
        scg_raw[2] <= 1'b0;
        ol_raw[2] <= 1'b1;
        cyc(990);
        check(32'(code(2)), 32'(CDF_NO_FAULT));
        poll(2, CDF_OPEN_LOAD, 2430);
        ahb(1'b0, CDF_REG_DIAG, 32'h0);
        check(rd, 32'h000F_FFDF);
        $display("done filter");
    endtask

    // Extended blind time on the first extended channel
    task automatic t_blind();
        ahb(1'b1, CDF_REG_CTRL, 32'h0000_07FF);
        scg_raw[6] <= 1'b1;
        cyc(33000);
        check(32'(code(6)), 32'(CDF_NO_FAULT));
        poll(6, CDF_SHORT_TO_GROUND, 36010);
        $display("done blind");
    endtask

    task automatic t_clear();
        ahb(1'b0, CDF_REG_CHK, 32'h0);
        check(rd, 32'h0000_0004);
        ol_raw[2] <= 1'b0;
        scg_raw[6] <= 1'b0;
        ahb(1'b1, CDF_REG_CTRL, 32'h0000_13FF);
        cyc(3);
        check(32'(lnk.diag_result_field), 32'(CDF_DIAG_RST));
        wait_idle();
        ahb(1'b0, CDF_REG_CHK, 32'h0);
        check(rd, 32'h0000_0000);
        $display("done clear");
    endtask

    task automatic t_gate();
        ahb(1'b1, CDF_REG_GATE, 32'h0000_03FF);
        cyc(3);
        check(32'(power_stage_n), 32'h0000_03FF);
        ahb(1'b1, CDF_REG_GATE, 32'h0000_02FF);
        cyc(3);
        check(32'(power_stage_n), 32'h0000_02FF);
        $display("done gate");
    endtask

    task automatic t_oct();
        oct_raw[3] <= 1'b1;
        poll(3, CDF_OVERCURRENT_OVERTEMP, 20);
        cyc(2);
        check(32'(power_stage_n[3]), 32'h0000_0000);
        oct_raw[3] <= 1'b0;
        $display("done overload");
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        scg_raw = 10'h000;
        ol_raw = 10'h000;
        oct_raw = 10'h000;
        num_errors = 0;
        checks = 0;
        cyc(4);
        hresetn <= 1'b1;
        cyc(1);
        t_regs();
        t_filter();
        t_blind();
        t_clear();
        t_gate();
        t_oct();
        give_verdict();
    end
endmodule
`default_nettype wire
